/* File: core/sbe_pkg.sv */
package sbe_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [11:0] SBE_FLAGS_OFS    = 12'h12c;
    localparam logic [11:0] SBE_SUPPRESS_OFS = 12'h130;
    localparam logic [31:0] SBE_FLAGS_RST    = 32'h0000_0000;
    localparam logic [31:0] SBE_SUPPRESS_RST = 32'h0000_17a8;

    // -----------------------------------------------------------------
    // field layout
    // -----------------------------------------------------------------
    localparam logic [31:0] SBE_FLAGS_IMPL    = 32'h0000_1e8c;
    localparam logic [31:0] SBE_SUPPRESS_IMPL = 32'h0000_3fee;
    localparam int          SBE_NUM_EVT       = 7;
    localparam int          SBE_PTR_W         = 5;
    localparam logic [4:0]  SBE_PTR_RST       = 5'h00;

    typedef logic [4:0] sbe_pos_t;
    // status bit positions, indexed by event number
    localparam sbe_pos_t SBE_EVT_POS [SBE_NUM_EVT] = '{
        5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h07, 5'h03, 5'h02
    };

endpackage : sbe_pkg

/* File: core/sbe_sync_if.sv */
interface sbe_sync_if;
    logic [6:0] raw;
    logic [6:0] clean;
    modport src (output raw, input clean);
    modport snk (input raw, output clean);
endinterface : sbe_sync_if

/* File: core/sbe_sync.sv */
module sbe_sync
    import sbe_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    sbe_sync_if.snk   sig
);
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
    } sbe_sync_state_t;

    sbe_sync_state_t st;
    sbe_sync_state_t next_st;

    // two stage chain, stage one feeds only stage two
    always_comb begin
        next_st    = st;
        next_st.s1 = sig.raw;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sig.clean = st.s2;
endmodule : sbe_sync

/* File: core/sbe_regs.sv */
// Functional notes
// - status bits clear only by writing one or by reset
// - bit 12 sets on system error seen
// - bit 11 sets on parity signal seen
// - bit 10 sets on discard timer expiry
// - bit 9 sets on address parity fault
// - bit 7 sets on data parity fault
// - bit 3 sets on received master abort
// - bit 2 sets on received target abort
// - unused status bits read zero
// - mask blocks status, message, log, pointer
// - mask register resets to 0x17a8
// - extended variant mask bits stored only
// - link, global, power-on reset restore defaults
// - status reads zero after reset
// - status at 0x12c, mask at 0x130
// - pointer records first unmasked error position
module sbe_regs
    import sbe_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        link_reset_n,
    input  wire logic        global_reset_input_n,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    input  wire logic        system_error_seen,
    input  wire logic        parity_signal_seen,
    input  wire logic        discard_timer_expired,
    input  wire logic        address_parity_fault,
    input  wire logic        data_parity_fault,
    input  wire logic        master_abort_rcvd,
    input  wire logic        target_abort_rcvd,
    output logic      [6:0]  fault_report,
    output logic             header_log_load,
    output logic      [4:0]  earliest_fault_pointer
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] suppress;
        logic [4:0]  ptr;
        logic        ptr_valid;
        logic [6:0]  report;
        logic        log_load;
        logic [31:0] rdata;
        logic [1:0]  rst_s1;
        logic [1:0]  rst_s2;
    } sbe_state_t;

    sbe_state_t st;
    sbe_state_t next_st;
    sbe_sync_if evt_if ();

    logic [6:0]  evt;
    logic [6:0]  live;
    logic [31:0] set_vec;
    logic [31:0] wmask;
    logic        soft_rst;
    logic [4:0]  first_pos;
    logic        any_live;

    // byte enables expanded to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    // address decode used by both read and write paths
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction : hit

    // -----------------------------------------------------------------
    // event inputs synchronised
    // -----------------------------------------------------------------
    assign evt_if.raw = {target_abort_rcvd, master_abort_rcvd,
                         data_parity_fault, address_parity_fault,
                         discard_timer_expired, parity_signal_seen,
                         system_error_seen};

    sbe_sync u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sig      (evt_if.snk)
    );

    assign evt = evt_if.clean;

    // -----------------------------------------------------------------
    // event routing
    // -----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SBE_NUM_EVT; gi++) begin : g_evt
            // unmasked event only
            assign live[gi] = evt[gi] &
                              ~st.suppress[SBE_EVT_POS[gi]];
        end
    endgenerate

    // status set vector and first-error position
    always_comb begin
        set_vec   = '0;
        first_pos = SBE_PTR_RST;
        any_live  = 1'b0;
        for (int i = SBE_NUM_EVT - 1; i >= 0; i--) begin
            if (live[i]) begin
                set_vec[SBE_EVT_POS[i]] = 1'b1;
                first_pos = SBE_EVT_POS[i];
                any_live  = 1'b1;
            end
        end
    end

    assign wmask    = be_mask(cfg_be) & cfg_wdata;
    // either reset pin low holds the soft reset
    assign soft_rst = !(&st.rst_s2);

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        next_st        = st;
        // each reset pin passes its own two flops before any logic
        next_st.rst_s1 = {link_reset_n, global_reset_input_n};
        next_st.rst_s2 = st.rst_s1;
        next_st.report = live;
        next_st.log_load = any_live;
        // write one clears, hardware set wins
        if (cfg_wr && hit(cfg_addr, SBE_FLAGS_OFS)) begin
            next_st.flags = st.flags & ~wmask;
        end
        next_st.flags = (next_st.flags | set_vec)
                        & SBE_FLAGS_IMPL;
        if (cfg_wr && hit(cfg_addr, SBE_SUPPRESS_OFS)) begin
            next_st.suppress = ((st.suppress & ~be_mask(cfg_be)) |
                                (cfg_wdata & be_mask(cfg_be)))
                               & SBE_SUPPRESS_IMPL;
        end
        // pointer follows the first unmasked error
        if (any_live && !st.ptr_valid) begin
            next_st.ptr       = first_pos;
            next_st.ptr_valid = 1'b1;
        end
        // read data from decoded register
        next_st.rdata = '0;
        if (cfg_rd) begin
            if (hit(cfg_addr, SBE_FLAGS_OFS)) begin
                next_st.rdata = st.flags & SBE_FLAGS_IMPL;
            end else if (hit(cfg_addr, SBE_SUPPRESS_OFS)) begin
                next_st.rdata = st.suppress;
            end else begin
                next_st.rdata = '0;
            end
        end
        if (soft_rst) begin
            next_st.flags     = SBE_FLAGS_RST;
            next_st.suppress  = SBE_SUPPRESS_RST;
            next_st.ptr       = SBE_PTR_RST;
            next_st.ptr_valid = 1'b0;
            next_st.report    = '0;
            next_st.log_load  = 1'b0;
        end
    end

    // state register, power-on reset asynchronous
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st          <= '0;
            st.suppress <= SBE_SUPPRESS_RST;
            // chains start released: no soft reset echo after power-on
            st.rst_s1   <= 2'b11;
            st.rst_s2   <= 2'b11;
        end else begin
            st <= next_st;
        end
    end

    assign cfg_rdata              = st.rdata;
    assign fault_report           = st.report;
    assign header_log_load        = st.log_load;
    assign earliest_fault_pointer = st.ptr;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    a_set_on_event: assert property (
        (evt[0] && !st.suppress[12] && !soft_rst) |=> st.flags[12])
        else $error("system error not recorded");
    a_mask_blocks_set: assert property (
        (st.suppress[11] && $stable(st.suppress) && !st.flags[11] &&
         !(cfg_wr && hit(cfg_addr, SBE_SUPPRESS_OFS)))
        |=> !st.flags[11] || !st.suppress[11])
        else $error("masked status bit set");
    a_flag_sticky: assert property (
        (st.flags[7] && !soft_rst &&
         !(cfg_wr && hit(cfg_addr, SBE_FLAGS_OFS))) |=> st.flags[7])
        else $error("status bit lost without clear");
    a_set_wins_clear: assert property (
        (live[6] && cfg_wr && hit(cfg_addr, SBE_FLAGS_OFS) &&
         !soft_rst) |=> st.flags[2])
        else $error("event lost to clear");
    a_unused_zero: assert property (
        (st.flags & ~SBE_FLAGS_IMPL) == 32'h0000_0000)
        else $error("unused status bit set");
    a_soft_reset_dflt: assert property (
        soft_rst |=> st.flags == SBE_FLAGS_RST &&
                     st.suppress == SBE_SUPPRESS_RST)
        else $error("reset did not restore defaults");
    a_ptr_first_hold: assert property (
        (st.ptr_valid && !soft_rst) |=> $stable(st.ptr))
        else $error("first error pointer moved");
    a_read_mask: assert property (
        (cfg_rd && hit(cfg_addr, SBE_SUPPRESS_OFS)) |=>
        cfg_rdata == $past(st.suppress))
        else $error("mask read mismatch");
    a_report_masked: assert property (
        (evt[6] && st.suppress[2]) |=> !fault_report[6])
        else $error("masked error reported");
    // header log strobe only for an unmasked error
    a_log_masked: assert property (
        (live == 7'h00 || soft_rst) |=> !header_log_load)
        else $error("header log loaded without unmasked error");
    // header log strobe follows any unmasked error
    a_log_follows: assert property (
        (live != 7'h00 && !soft_rst) |=> header_log_load)
        else $error("header log not loaded");

    // -----------------------------------------------------------------
    // pointer and reset checks
    // -----------------------------------------------------------------
    // masked errors leave the pointer empty
    a_ptr_masked: assert property (
        (!st.ptr_valid && live == 7'h00 && !soft_rst) |=> !st.ptr_valid)
        else $error("pointer loaded without unmasked error");
    // pointer loads the position of the first unmasked error
    a_ptr_loads: assert property (
        (!st.ptr_valid && live == 7'h40 && !soft_rst) |=>
        earliest_fault_pointer == SBE_EVT_POS[6])
        else $error("pointer missed target abort position");
    // system error wins the pointer over other events of its cycle
    a_ptr_sys_first: assert property (
        (!st.ptr_valid && live[0] && !soft_rst) |=>
        earliest_fault_pointer == SBE_EVT_POS[0])
        else $error("pointer missed system error position");
    // soft reset empties the pointer
    a_soft_reset_ptr: assert property (
        soft_rst |=> !st.ptr_valid &&
                     earliest_fault_pointer == SBE_PTR_RST)
        else $error("reset did not clear pointer");

    // -----------------------------------------------------------------
    // register bus checks
    // -----------------------------------------------------------------
    // write one clears, unless the event lands in the same cycle
    a_clear_lands: assert property (
        (cfg_wr && hit(cfg_addr, SBE_FLAGS_OFS) && cfg_be[1] &&
         cfg_wdata[11] && !live[1] && !soft_rst) |=> !st.flags[11])
        else $error("write one did not clear");
    // full-word mask write lands, trimmed to the implemented bits
    a_mask_write: assert property (
        (cfg_wr && hit(cfg_addr, SBE_SUPPRESS_OFS) && cfg_be == 4'hf &&
         !soft_rst) |=>
        st.suppress == ($past(cfg_wdata) & SBE_SUPPRESS_IMPL))
        else $error("mask write not stored");
    // disabled byte lanes keep their mask bits
    a_mask_lane_keep: assert property (
        (cfg_wr && hit(cfg_addr, SBE_SUPPRESS_OFS) && !cfg_be[1] &&
         !soft_rst) |=> st.suppress[15:8] == $past(st.suppress[15:8]))
        else $error("mask lane changed without enable");
    // status read returns the flags of the request cycle
    a_flags_read: assert property (
        (cfg_rd && hit(cfg_addr, SBE_FLAGS_OFS)) |=>
        cfg_rdata == $past(st.flags))
        else $error("status read mismatch");
    // read data is zero outside a read answer
    a_rdata_idle: assert property (
        !cfg_rd |=> cfg_rdata == 32'h0000_0000)
        else $error("read data outside a read");
    // unmapped offsets read as zero
    a_unmapped_zero: assert property (
        (cfg_rd && !hit(cfg_addr, SBE_FLAGS_OFS) &&
         !hit(cfg_addr, SBE_SUPPRESS_OFS)) |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // -----------------------------------------------------------------
    // per event checks
    // -----------------------------------------------------------------
    generate
        for (gi = 0; gi < SBE_NUM_EVT; gi++) begin : g_evt_chk
            // unmasked event lands in its status bit
            a_evt_lands: assert property (
                (evt[gi] && !st.suppress[SBE_EVT_POS[gi]] && !soft_rst)
                |=> st.flags[SBE_EVT_POS[gi]])
                else $error("unmasked event not recorded");
            // masked event leaves a clear status bit clear
            a_evt_masked: assert property (
                (evt[gi] && st.suppress[SBE_EVT_POS[gi]] &&
                 !st.flags[SBE_EVT_POS[gi]])
                |=> !st.flags[SBE_EVT_POS[gi]])
                else $error("masked event recorded");
            // masked event raises no message pulse
            a_evt_no_msg: assert property (
                (evt[gi] && st.suppress[SBE_EVT_POS[gi]]) |=>
                !fault_report[gi])
                else $error("masked error reported");
            // unmasked event raises its message pulse
            a_evt_msg: assert property (
                (live[gi] && !soft_rst) |=> fault_report[gi])
                else $error("unmasked error not reported");
            // set wins over a same-cycle clear of the bit
            a_evt_set_wins: assert property (
                (live[gi] && cfg_wr && hit(cfg_addr, SBE_FLAGS_OFS) &&
                 !soft_rst) |=> st.flags[SBE_EVT_POS[gi]])
                else $error("event lost to a clear");
        end
    endgenerate

    // -----------------------------------------------------------------
    // cover points
    // -----------------------------------------------------------------

    c_target_abort: cover property (live[6] ##1 st.flags[2]);
    c_clear_flag: cover property (
        st.flags[11] ##1 !st.flags[11]);
    c_ptr_load: cover property (!st.ptr_valid ##1 st.ptr_valid);
    c_set_wins: cover property (
        live[6] && cfg_wr && hit(cfg_addr, SBE_FLAGS_OFS));
    c_soft_reset: cover property (!soft_rst ##1 soft_rst);
endmodule : sbe_regs

/* File: dv/sbe_pci_agents.sv */
module sbe_pci_agents (
    input  wire logic       core_clk,
    output logic      [6:0] evt
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus: no condition reported
    initial evt = 7'h00;

    // one-cycle condition pulse per set bit, launched off the falling edge
    task automatic fire(input logic [6:0] which);
        @(negedge core_clk);
        evt = which;
        @(negedge core_clk);
        evt = 7'h00;
    endtask : fire

endmodule : sbe_pci_agents

/* File: dv/secondary_bus_error_status_mask_bench.sv */
module secondary_bus_error_status_mask_bench;
    import sbe_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk, arst_n, link_reset_n, global_reset_input_n;
    logic        cfg_wr, cfg_rd, header_log_load, log_seen;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, rd_val, acc;
    logic [6:0]  evt, fault_report, rpt_seen;
    logic [4:0]  earliest_fault_pointer;
    int          err_total, n_checks, cycles;

    sbe_regs u_sbe_regs (
        .core_clk(core_clk), .arst_n(arst_n), .link_reset_n(link_reset_n),
        .global_reset_input_n(global_reset_input_n), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .system_error_seen(evt[0]), .parity_signal_seen(evt[1]),
        .discard_timer_expired(evt[2]), .address_parity_fault(evt[3]),
        .data_parity_fault(evt[4]), .master_abort_rcvd(evt[5]),
        .target_abort_rcvd(evt[6]), .fault_report(fault_report),
        .header_log_load(header_log_load),
        .earliest_fault_pointer(earliest_fault_pointer));

    sbe_pci_agents u_sbe_pci_agents (.core_clk(core_clk), .evt(evt));

    // ---------------------------------------------------------------
    // clock, report capture and hang guard
    // ---------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // outputs captured mid-cycle, where they are settled
    always @(negedge core_clk) begin
        rpt_seen = rpt_seen | fault_report;
        log_seen = log_seen | header_log_load;
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // access and compare tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cfg_write(input logic [11:0] a, input logic [3:0] be,
                             input logic [31:0] d);
        @(negedge core_clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge core_clk);
        cfg_wr = 1'b0;
    endtask : cfg_write

    task automatic read_chk(input string what, input logic [11:0] a,
                            input logic [31:0] exp);
        @(negedge core_clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge core_clk);
        cfg_rd = 1'b0;
        rd_val = cfg_rdata;
        check(what, rd_val, exp);
    endtask : read_chk

    task automatic close_out();
        $display("mismatches %0d checks %0d", err_total, n_checks);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        {arst_n, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
        {link_reset_n, global_reset_input_n} = 2'b11;
        {rpt_seen, log_seen, err_total, n_checks, cycles} = '0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) arst_n = 1'b1;
        read_chk("flags reset", SBE_FLAGS_OFS, 32'h0);
        read_chk("mask reset", SBE_SUPPRESS_OFS, 32'h0000_17a8);
        cfg_write(SBE_SUPPRESS_OFS, 4'h1, 32'hffff_ffff);
        read_chk("mask lane0", SBE_SUPPRESS_OFS, 32'h0000_17ee);
        cfg_write(12'h134, 4'hf, 32'hffff_ffff);
        read_chk("unmapped", 12'h134, 32'h0);
        cfg_write(SBE_FLAGS_OFS, 4'hf, 32'hffff_ffff);
        read_chk("flags unused", SBE_FLAGS_OFS, 32'h0);
        // only the extended-variant bits masked: all conditions still land
        cfg_write(SBE_SUPPRESS_OFS, 4'hf, 32'h0000_2162);
        read_chk("mask ext", SBE_SUPPRESS_OFS, 32'h0000_2162);
        acc = '0;
        for (int i = SBE_NUM_EVT - 1; i >= 0; i--) begin
            u_sbe_pci_agents.fire(7'h01 << i);
            repeat (6) @(negedge core_clk);
            acc[SBE_EVT_POS[i]] = 1'b1;
            read_chk("flag set", SBE_FLAGS_OFS, acc);
        end
        check("pointer", 32'(earliest_fault_pointer), 32'h2);
        check("report", {24'h0, log_seen, rpt_seen}, 32'hff);
        cfg_write(SBE_FLAGS_OFS, 4'hf, 32'h0);
        read_chk("write zero", SBE_FLAGS_OFS, acc);
        cfg_write(SBE_FLAGS_OFS, 4'hf, 32'h0000_0800);
        read_chk("clear one", SBE_FLAGS_OFS, acc & ~32'h800);
        cfg_write(SBE_FLAGS_OFS, 4'hf, 32'hffff_ffff);
        read_chk("clear all", SBE_FLAGS_OFS, 32'h0);
        // clear lands on the same edge as the target abort setting bit 2
        fork
            u_sbe_pci_agents.fire(7'h40);
            begin
                repeat (2) @(negedge core_clk);
                cfg_write(SBE_FLAGS_OFS, 4'hf, 32'h0000_0004);
            end
        join
        repeat (6) @(negedge core_clk);
        read_chk("set wins", SBE_FLAGS_OFS, 32'h0000_0004);
        cfg_write(SBE_FLAGS_OFS, 4'hf, 32'hffff_ffff);
        cfg_write(SBE_SUPPRESS_OFS, 4'hf, SBE_SUPPRESS_IMPL);
        rpt_seen = '0;
        log_seen = 1'b0;
        u_sbe_pci_agents.fire(7'h7f);
        repeat (6) @(negedge core_clk);
        read_chk("masked", SBE_FLAGS_OFS, 32'h0);
        check("masked rpt", {24'h0, log_seen, rpt_seen}, 32'h0);
        check("masked ptr", 32'(earliest_fault_pointer), 32'h2);
        // link reset, then global reset, restore defaults
        for (int r = 0; r < 2; r++) begin
            cfg_write(SBE_SUPPRESS_OFS, 4'hf, 32'h0);
            u_sbe_pci_agents.fire(7'h01);
            repeat (6) @(negedge core_clk);
            read_chk("pre rst", SBE_FLAGS_OFS, 32'h0000_1000);
            acc = (r == 0) ? 32'h0000_0002 : 32'h0000_000c;
            check("pre ptr", 32'(earliest_fault_pointer), acc);
            if (r == 0) link_reset_n = 1'b0;
            else global_reset_input_n = 1'b0;
            repeat (4) @(negedge core_clk);
            {link_reset_n, global_reset_input_n} = 2'b11;
            repeat (6) @(negedge core_clk);
            read_chk("rst flags", SBE_FLAGS_OFS, 32'h0);
            read_chk("rst mask", SBE_SUPPRESS_OFS, 32'h0000_17a8);
            check("rst ptr", 32'(earliest_fault_pointer), 32'h0);
        end
        close_out();
    end

endmodule : secondary_bus_error_status_mask_bench
